// >>> design/asmsq_pkg.sv
// constants, states and timing for the converter mode sequencer
package asmsq_pkg;
	// clock and time figures
	localparam int          CLK_PERIOD_NS    = 25;
	localparam int          INT_CONV_MAX_NS  = 6000;
	localparam int          INT_CONV_CYCLES  = INT_CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int          CAL_CYCLES_DEF   = 80000;
	// frame lengths and acquisition ends in serial clocks
	localparam logic [5:0]  FRAME_SHORT      = 6'h18;
	localparam logic [5:0]  FRAME_LONG       = 6'h20;
	localparam logic [5:0]  ACQ_END_SHORT    = 6'h06;
	localparam logic [5:0]  ACQ_END_LONG     = 6'h0e;
	localparam logic [5:0]  READ_BITS        = 6'h10;
	localparam logic [5:0]  CTRL_DECODE_BIT  = 6'h07;
	localparam logic [3:0]  READ_LAST        = 4'hf;
	// control byte bit positions after seven bits shifted in
	localparam int          POS_UNI          = 5;
	localparam int          POS_INT          = 4;
	localparam int          POS_M1           = 3;
	localparam int          POS_M0           = 2;
	localparam int          POS_P2           = 1;
	localparam int          POS_P1           = 0;
	// mode codes
	localparam logic [1:0]  MODE_SHORT       = 2'h0;
	localparam logic [1:0]  MODE_CAL         = 2'h1;
	localparam logic [1:0]  MODE_POWER_DOWN_PIN        = 2'h2;
	localparam logic [1:0]  MODE_LONG        = 2'h3;
	// values after reset
	localparam logic        RST_UNI          = 1'b0;
	localparam logic        RST_INT_CLK      = 1'b1;
	localparam logic [2:0]  RST_USER         = 3'h0;
	// sync flops clear to idle pins: clock low, data low, select and shutdown high
	localparam logic [3:0]  RST_PINS         = 4'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CTRL  = 3'b001,
		ST_CONV  = 3'b011,
		ST_READ  = 3'b010,
		ST_ICONV = 3'b110,
		ST_CAL   = 3'b111,
		ST_SLEEP = 3'b101
	} asmsq_state_t;
endpackage : asmsq_pkg

// >>> design/asmsq_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module asmsq_sync #(
	parameter int           W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage; reset to idle levels avoids false events
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : asmsq_sync
`default_nettype wire

// >>> design/asmsq_top.sv
// serial mode sequencer of a 14-bit successive-approximation converter
//
// Function
// R01: mode 00: 5.5 acquisition, 24-clock frame
// R02: mode 11: 13.5 acquisition, 32-clock frame
// R03: control byte mode 01 starts calibration
// R04: calibration lasts about 80,000 clocks
// R05: reset, shutdown pin, start bit abort calibration
// R06: mode 10: finish conversion, then power down
// R07: power-down wakes on new start bit
// R08: shutdown-mode conversion reuses previous acquisition length
// R09: host uses three byte transfers per conversion; mode 11 frames here take 32 clocks, four bytes
// R10: host limits external short unipolar to 125ksps
// R11: external long mode runs 150ksps both polarities
// R12: host switches mux right after acquisition
// R13: host calibrates in the clock mode used
// R14: host recalibrates when clocking changes
// R15: first high data bit while idle starts
// R16: conversion begins after seventh control bit fall
// R17: result shifted out most significant bit first
// R18: reset: user outputs low, bipolar, internal clock
// R19: host supplies every clock of the frame
`timescale 1ns/1ps
`default_nettype none
module asmsq_top #(
	parameter int CAL_CYCLES = asmsq_pkg::CAL_CYCLES_DEF
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        sclk_pin,
	input  wire logic        din_pin,
	input  wire logic        cs_n_pin,
	input  wire logic        power_down_pin_n,
	input  wire logic [13:0] result_data,
	output var  logic        dout,
	output var  logic        dout_oe,
	output var  logic        conversion_strobe,
	output var  logic        user_output_0,
	output var  logic        user_output_1,
	output var  logic        user_output_2,
	output var  logic        polarity_select,
	output var  logic        int_clock_mode,
	output var  logic        mode_sel_hi,
	output var  logic        mode_sel_lo,
	output var  logic        acquiring,
	output var  logic        converting,
	output var  logic        calibrating,
	output var  logic        powered_down
);
	typedef struct packed {
		asmsq_pkg::asmsq_state_t state;
		logic                    sclk_d;
		logic [5:0]              bitcnt;
		logic [6:0]              shreg;
		logic                    uni;
		logic                    int_clk;
		logic                    acq_long;
		logic [1:0]              mode;
		logic [2:0]              user;
		logic [15:0]             out_sh;
		logic [3:0]              rd_cnt;
		logic [16:0]             cnt;
		logic                    pd_pending;
		logic                    rearm;
		logic                    dout;
		logic                    dout_oe;
		logic                    strobe;
		logic                    acq;
		logic                    conv;
		logic                    cal;
		logic                    pd;
	} asmsq_regs_t;

	asmsq_regs_t r_reg;
	asmsq_regs_t r_next;
	logic [3:0]  pins_sync;
	logic        s_sclk;
	logic        s_din;
	logic        s_cs_n;
	logic        s_pd_n;

	// cleared flops must read as idle pins, else reset looks like a shutdown request
	asmsq_sync #(.W(4), .RST_VAL(asmsq_pkg::RST_PINS)) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({sclk_pin, din_pin, cs_n_pin, power_down_pin_n}),
		.sync_out (pins_sync)
	);
	assign {s_sclk, s_din, s_cs_n, s_pd_n} = pins_sync;

	// frame length for the chosen acquisition
	function automatic logic [5:0] frame_len(input logic lng);
		frame_len = lng ? asmsq_pkg::FRAME_LONG : asmsq_pkg::FRAME_SHORT; // [R01] [R02]
	endfunction : frame_len

	// restart the frame on a start bit
	function automatic asmsq_regs_t begin_frame(input asmsq_regs_t v);
		asmsq_regs_t o;
		o        = v;
		o.state  = asmsq_pkg::ST_CTRL;
		o.shreg  = 7'h01;
		o.bitcnt = 6'h01;
		o.acq    = 1'b1;
		o.rearm  = 1'b0;
		o.dout   = 1'b0;
		begin_frame = o;
	endfunction : begin_frame

	// next-state logic of the whole sequencer
	always_comb begin
		logic rise;
		logic fall;
		logic start_hit;
		logic [1:0] m;
		rise      = s_sclk & ~r_reg.sclk_d;
		fall      = ~s_sclk & r_reg.sclk_d;
		start_hit = rise & ~s_cs_n & s_din;
		m         = 2'h0;
		r_next        = r_reg;
		r_next.sclk_d = s_sclk;
		r_next.dout_oe = ~s_cs_n;
		if (s_cs_n) begin
			r_next.rearm = 1'b1;
		end
		// count serial clocks and catch the last user bit in any busy state
		if (rise && r_reg.state != asmsq_pkg::ST_IDLE && r_reg.state != asmsq_pkg::ST_SLEEP) begin
			r_next.bitcnt = r_reg.bitcnt + 6'h01;
			if (r_reg.bitcnt == asmsq_pkg::CTRL_DECODE_BIT) begin
				r_next.user[0] = s_din;
			end
		end
		// end of acquisition window
		if (fall && r_reg.acq && r_reg.state != asmsq_pkg::ST_CTRL) begin
			if (r_reg.bitcnt == (r_reg.acq_long ? asmsq_pkg::ACQ_END_LONG
					: asmsq_pkg::ACQ_END_SHORT)) begin
				r_next.acq = 1'b0; // [R01] [R02]
			end
		end
		case (r_reg.state)
			asmsq_pkg::ST_IDLE, asmsq_pkg::ST_SLEEP: begin
				if (start_hit) begin
					r_next = begin_frame(r_next); // [R15] [R07]
				end
			end
			asmsq_pkg::ST_CTRL: begin
				if (rise) begin
					r_next.shreg = {r_reg.shreg[5:0], s_din};
				end
				// short acquisition ends on fall six, before the byte is decoded
				if (fall && r_reg.bitcnt == asmsq_pkg::ACQ_END_SHORT) begin
					m = {r_reg.shreg[asmsq_pkg::POS_M1 - 1], r_reg.shreg[asmsq_pkg::POS_M0 - 1]};
					if (m == asmsq_pkg::MODE_SHORT
							|| (m == asmsq_pkg::MODE_POWER_DOWN_PIN && !r_reg.acq_long)) begin
						r_next.acq = 1'b0; // [R01] [R08]
					end
				end
				// decode once the seventh bit is in, act on its falling edge
				if (fall && r_reg.bitcnt == asmsq_pkg::CTRL_DECODE_BIT) begin
					m               = {r_reg.shreg[asmsq_pkg::POS_M1], r_reg.shreg[asmsq_pkg::POS_M0]};
					r_next.uni      = r_reg.shreg[asmsq_pkg::POS_UNI];
					r_next.int_clk  = r_reg.shreg[asmsq_pkg::POS_INT];
					r_next.user[2]  = r_reg.shreg[asmsq_pkg::POS_P2];
					r_next.user[1]  = r_reg.shreg[asmsq_pkg::POS_P1];
					r_next.mode     = m;
					r_next.pd_pending = (m == asmsq_pkg::MODE_POWER_DOWN_PIN); // [R06]
					if (m != asmsq_pkg::MODE_POWER_DOWN_PIN) begin
						r_next.acq_long = (m == asmsq_pkg::MODE_LONG); // [R08]
					end
					r_next.cnt = 17'h0_0000;
					if (m == asmsq_pkg::MODE_CAL) begin
						r_next.state  = asmsq_pkg::ST_CAL; // [R03]
						r_next.acq    = 1'b0;
						r_next.strobe = ~r_reg.shreg[asmsq_pkg::POS_INT];
					end else if (r_reg.shreg[asmsq_pkg::POS_INT]) begin
						r_next.state  = asmsq_pkg::ST_ICONV; // [R16]
						r_next.acq    = 1'b0;
						r_next.strobe = 1'b0;
					end else begin
						r_next.state  = asmsq_pkg::ST_CONV; // [R16]
					end
				end
			end
			asmsq_pkg::ST_CONV: begin
				// readout takes the last sixteen clocks of the frame
				if (fall && r_reg.bitcnt == frame_len(r_reg.acq_long) - asmsq_pkg::READ_BITS) begin
					r_next.state  = asmsq_pkg::ST_READ;
					r_next.out_sh = {result_data[12:0], 3'h0};
					r_next.dout   = result_data[13]; // [R17]
					r_next.rd_cnt = 4'h0;
					r_next.strobe = 1'b1;
				end
			end
			asmsq_pkg::ST_ICONV: begin
				r_next.cnt = r_reg.cnt + 17'h0_0001;
				if (r_reg.cnt == 17'(asmsq_pkg::INT_CONV_CYCLES - 1)) begin
					r_next.state  = asmsq_pkg::ST_READ;
					r_next.out_sh = {result_data[12:0], 3'h0};
					r_next.dout   = result_data[13]; // [R17]
					r_next.rd_cnt = 4'h0;
					r_next.strobe = 1'b1;
				end
			end
			asmsq_pkg::ST_READ: begin
				if (!r_reg.int_clk) begin
					r_next.strobe = 1'b0; // external strobe is a one-cycle mark
				end
				if (fall) begin
					if (r_reg.rd_cnt == asmsq_pkg::READ_LAST) begin
						r_next.dout  = 1'b0;
						r_next.state = r_reg.pd_pending ? asmsq_pkg::ST_SLEEP
							: asmsq_pkg::ST_IDLE; // [R06] [R01] [R02]
					end else begin
						r_next.dout   = r_reg.out_sh[15]; // [R17]
						r_next.out_sh = {r_reg.out_sh[14:0], 1'b0};
						r_next.rd_cnt = r_reg.rd_cnt + 4'h1;
					end
				end
			end
			asmsq_pkg::ST_CAL: begin
				r_next.cnt = r_reg.cnt + 17'h0_0001;
				if (r_reg.cnt == 17'(CAL_CYCLES - 1)) begin
					r_next.state  = asmsq_pkg::ST_IDLE; // [R04]
					r_next.strobe = r_reg.int_clk;
				end
			end
			default: begin
				r_next.state = asmsq_pkg::ST_IDLE;
			end
		endcase
		// a fresh start bit after chip select pulsed high ends the current job
		if (r_reg.rearm && start_hit && r_reg.state != asmsq_pkg::ST_IDLE
				&& r_reg.state != asmsq_pkg::ST_SLEEP) begin
			r_next        = begin_frame(r_next); // [R05] [R15]
			r_next.strobe = r_reg.int_clk;
		end
		// shutdown pin overrides everything, calibration included
		if (!s_pd_n) begin
			r_next.state  = asmsq_pkg::ST_SLEEP; // [R05]
			r_next.acq    = 1'b0;
			r_next.dout   = 1'b0;
			r_next.strobe = r_reg.int_clk;
		end
		r_next.conv = (r_next.state == asmsq_pkg::ST_CONV || r_next.state == asmsq_pkg::ST_ICONV);
		r_next.cal  = (r_next.state == asmsq_pkg::ST_CAL);
		r_next.pd   = (r_next.state == asmsq_pkg::ST_SLEEP);
	end

	// single state register; reset gives bipolar, internal clock, user outputs low, strobe high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_reg            <= '0; // [R05]
			r_reg.state      <= asmsq_pkg::ST_IDLE;
			r_reg.uni        <= asmsq_pkg::RST_UNI; // [R18]
			r_reg.int_clk    <= asmsq_pkg::RST_INT_CLK; // [R18]
			r_reg.user       <= asmsq_pkg::RST_USER; // [R18]
			r_reg.strobe     <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign dout              = r_reg.dout;
	assign dout_oe           = r_reg.dout_oe;
	assign conversion_strobe = r_reg.strobe;
	assign user_output_0     = r_reg.user[0];
	assign user_output_1     = r_reg.user[1];
	assign user_output_2     = r_reg.user[2];
	assign polarity_select   = r_reg.uni;
	assign int_clock_mode    = r_reg.int_clk;
	assign mode_sel_hi       = r_reg.mode[1];
	assign mode_sel_lo       = r_reg.mode[0];
	assign acquiring         = r_reg.acq;
	assign converting        = r_reg.conv;
	assign calibrating       = r_reg.cal;
	assign powered_down      = r_reg.pd;
endmodule : asmsq_top
`default_nettype wire

// >>> sim/asmsq_checker.sv
// port assertions for the converter mode sequencer
`timescale 1ns/1ps
`default_nettype none
module asmsq_checker #(
	parameter int CAL_CYCLES = 50
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclk_pin,
	input wire logic power_down_pin_n,
	input wire logic conversion_strobe,
	input wire logic user_output_0,
	input wire logic user_output_1,
	input wire logic user_output_2,
	input wire logic polarity_select,
	input wire logic int_clock_mode,
	input wire logic mode_sel_hi,
	input wire logic mode_sel_lo,
	input wire logic acquiring,
	input wire logic converting,
	input wire logic calibrating,
	input wire logic powered_down
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	int cal_cnt;
	// run length of calibration; too long for a repetition
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cal_cnt <= 0;
		else
			cal_cnt <= calibrating ? cal_cnt + 1 : 0;
	end
	AST_RST_DEFAULTS: assert property ($rose(resetn) |-> conversion_strobe && int_clock_mode
		&& !polarity_select && !(user_output_0 || user_output_1 || user_output_2))
		else $error("reset values wrong");
	AST_CAL_MODE: assert property ($rose(calibrating) |-> ##[0:1] (!mode_sel_hi && mode_sel_lo))
		else $error("calibration without mode 01");
	AST_CAL_MIN: assert property ($rose(calibrating) |-> calibrating [*8])
		else $error("calibration ended early");
	AST_CAL_MAX: assert property (cal_cnt <= CAL_CYCLES + 1)
		else $error("calibration overran");
	AST_PIN_ABORT: assert property (!power_down_pin_n [*5] |-> powered_down && !calibrating)
		else $error("shutdown pin ignored");
	AST_SLEEP_MODE: assert property ($rose(powered_down) && power_down_pin_n |-> mode_sel_hi && !mode_sel_lo)
		else $error("sleep without mode 10");
	AST_SLEEP_IDLE: assert property (powered_down |-> !converting && !calibrating)
		else $error("busy while asleep");
	AST_WAKE: assert property ($fell(powered_down) && $past(power_down_pin_n, 6) |-> ##[0:2] (acquiring || converting))
		else $error("woke without start bit");
	AST_CONV_EDGE: assert property ($rose(converting) |-> !$past(sclk_pin))
		else $error("conversion not on falling clock");
	// main scenarios reached
	cover property ($rose(calibrating));
	cover property ($rose(powered_down));
	cover property ($rose(converting) && int_clock_mode);
endmodule : asmsq_checker
bind asmsq_top asmsq_checker #(.CAL_CYCLES(CAL_CYCLES)) u_asmsq_checker (.clk, .resetn,
	.sclk_pin, .power_down_pin_n, .conversion_strobe, .user_output_0, .user_output_1,
	.user_output_2, .polarity_select, .int_clock_mode, .mode_sel_hi, .mode_sel_lo,
	.acquiring, .converting, .calibrating, .powered_down);
`default_nettype wire

// >>> sim/asmsq_host.sv
// serial host model: clocks control bytes in and results out
`timescale 1ns/1ps
`default_nettype none
module asmsq_host (
	input  wire logic clk,
	input  wire logic dout,
	input  wire logic conversion_strobe,
	output var  logic sclk_pin,
	output var  logic din_pin,
	output var  logic cs_n_pin
);
	// idle: clock parked low, data low so no false start bit
	initial begin
		sclk_pin = 1'b0;
		din_pin = 1'b0;
		cs_n_pin = 1'b1;
	end
	// n serial clocks, 200 ns each; rx keeps the last 16 samples
	task automatic frame(input logic [7:0] c, input int n, output logic [15:0] rx, output logic ok);
		int w;
		ok = 1'b1;
		rx = 16'h0000;
		@(posedge clk);
		cs_n_pin <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			din_pin <= (i < 8) ? c[7 - i] : 1'b0;
			if (i == 8 && c[5]) begin
				// internal clock: stay parked until the strobe says done
				repeat (8) @(posedge clk);
				w = 0;
				while (!conversion_strobe && w < 400) begin
					@(posedge clk);
					w++;
				end
				ok = (w < 400);
			end
			repeat (4) @(posedge clk);
			sclk_pin <= 1'b1;
			repeat (2) @(posedge clk);
			rx = {rx[14:0], dout};
			repeat (2) @(posedge clk);
			sclk_pin <= 1'b0;
		end
		repeat (12) @(posedge clk);
		cs_n_pin <= 1'b1;
		repeat (n < 24 ? 1 : 120) @(posedge clk);
	endtask : frame
endmodule : asmsq_host
`default_nettype wire

// >>> sim/test_adc_serial_mode_sequencer.sv
// self-checking bench for the converter mode sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_mode_sequencer;
	typedef struct packed {
		logic [7:0]  c;
		logic [5:0]  n;
		logic [13:0] r;
		logic        pd;
	} asmsq_row_t;
	asmsq_row_t  rows [6] = '{'{8'hc5, 6'h18, 14'h2a5c, 1'b0}, '{8'h9a, 6'h20, 14'h3fff, 1'b0},
		'{8'h93, 6'h20, 14'h0001, 1'b1}, '{8'hc0, 6'h18, 14'h1000, 1'b0},
		'{8'ha7, 6'h18, 14'h2001, 1'b0}, '{8'h90, 6'h18, 14'h0abc, 1'b1}};
	logic        clk              = 1'b0;
	logic        resetn           = 1'b0;
	logic        power_down_pin_n = 1'b1;
	logic [13:0] result_data      = 14'h0000;
	logic [15:0] rx;
	logic        ok;
	int          cal_len;
	int          err_total;
	int          checks_done;
	wire         sclk_pin, din_pin, cs_n_pin, dout, dout_oe, conversion_strobe;
	wire         user_output_0, user_output_1, user_output_2, polarity_select;
	wire         int_clock_mode, mode_sel_hi, mode_sel_lo, acquiring, converting;
	wire         calibrating, powered_down;
	// short calibration keeps the run brief
	asmsq_top #(.CAL_CYCLES(50)) u_asmsq_top (.clk, .resetn, .sclk_pin, .din_pin, .cs_n_pin,
		.power_down_pin_n, .result_data, .dout, .dout_oe, .conversion_strobe, .user_output_0,
		.user_output_1, .user_output_2, .polarity_select, .int_clock_mode, .mode_sel_hi,
		.mode_sel_lo, .acquiring, .converting, .calibrating, .powered_down);
	asmsq_host u_asmsq_host (.clk, .dout, .conversion_strobe, .sclk_pin, .din_pin, .cs_n_pin);
	always #12.5 clk = ~clk;
	// cycles spent calibrating, cleared by the scenario measuring it
	always @(posedge clk) if (calibrating) cal_len++;
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		// rows: frame length, readout, latched fields, sleep
		foreach (rows[k]) begin
			result_data <= rows[k].r;
			u_asmsq_host.frame(rows[k].c, rows[k].n, rx, ok);
			chk("wait", 1'h1, ok);
			if (ok !== 1'b1) conclude();
			chk("result", {rows[k].r, 2'h0}, rx);
			chk("fields", rows[k].c[6:0], {polarity_select, int_clock_mode, mode_sel_hi,
				mode_sel_lo, user_output_2, user_output_1, user_output_0});
			chk("sleep", rows[k].pd, powered_down);
			// acquisition over by frame end, so the mux select bits may move
			chk("acq end", 1'h0, acquiring);
		end
		// full calibration from sleep, same clock mode as frames, after a clock mode change
		cal_len = 0;
		u_asmsq_host.frame(8'h88, 8, rx, ok);
		chk("cal mode", 2'h1, {mode_sel_hi, mode_sel_lo});
		repeat (60) @(posedge clk);
		chk("cal length", 1'h1, cal_len inside {[50:52]});
		// shutdown pin cuts calibration short
		u_asmsq_host.frame(8'h88, 8, rx, ok);
		power_down_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("pin abort", 2'h1, {calibrating, powered_down});
		power_down_pin_n <= 1'b1;
		repeat (8) @(posedge clk);
		// start bit after a select pulse restarts mid-calibration
		u_asmsq_host.frame(8'h88, 8, rx, ok);
		result_data <= 14'h1234;
		u_asmsq_host.frame(8'hc0, 24, rx, ok);
		chk("restart", {14'h1234, 2'h0}, {rx[15:1], calibrating});
		// reset pin during a mode 01 calibration
		u_asmsq_host.frame(8'hcf, 8, rx, ok);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("reset", 8'hc0, {conversion_strobe, int_clock_mode, polarity_select,
			user_output_2, user_output_1, user_output_0, calibrating, dout_oe});
		conclude();
	end
endmodule : test_adc_serial_mode_sequencer
`default_nettype wire
